// file: common/rdw_pkg.sv
package rdw_pkg;
  localparam int          PARAM_W       = 8;
  // Read parameter register field positions
  localparam int          BURST_LO_POS  = 0;
  localparam int          BURST_HI_POS  = 1;
  localparam int          WRAP_EN_POS   = 2;
  localparam int          DUMMY_LO_POS  = 3;
  localparam int          DUMMY_HI_POS  = 6;
  localparam logic [7:0]  PARAM_RST     = 8'h00;
  // Wrap lengths in bytes, indexed by the two burst-size bits
  localparam logic [6:0]  WRAP_LEN_8    = 7'h08;
  localparam logic [6:0]  WRAP_LEN_16   = 7'h10;
  localparam logic [6:0]  WRAP_LEN_32   = 7'h20;
  localparam logic [6:0]  WRAP_LEN_64   = 7'h40;
  localparam logic [6:0]  WRAP_LEN_NONE = 7'h00;
  // Default dummy counts
  localparam logic [3:0]  DUMMY_ZERO    = 4'h0;
  localparam logic [3:0]  DUMMY_DEF_4   = 4'h4;
  localparam logic [3:0]  DUMMY_DEF_6   = 4'h6;
  localparam logic [3:0]  DUMMY_DEF_8   = 4'h8;
  // Read opcodes
  localparam logic [7:0]  OP_FAST_RD    = 8'h0B;
  localparam logic [7:0]  OP_FAST_RD4   = 8'h0C;
  localparam logic [7:0]  OP_FAST_DTR   = 8'h0D;
  localparam logic [7:0]  OP_FAST_DTR4  = 8'h0E;
  localparam logic [7:0]  OP_DUAL_OUT   = 8'h3B;
  localparam logic [7:0]  OP_DUAL_OUT4  = 8'h3C;
  localparam logic [7:0]  OP_QUAD_OUT   = 8'h6B;
  localparam logic [7:0]  OP_QUAD_OUT4  = 8'h6C;
  localparam logic [7:0]  OP_DUAL_IO    = 8'hBB;
  localparam logic [7:0]  OP_DUAL_IO4   = 8'hBC;
  localparam logic [7:0]  OP_DUAL_DTR   = 8'hBD;
  localparam logic [7:0]  OP_DUAL_DTR4  = 8'hBE;
  localparam logic [7:0]  OP_QUAD_IO    = 8'hEB;
  localparam logic [7:0]  OP_QUAD_IO4   = 8'hEC;
  localparam logic [7:0]  OP_QUAD_DTR   = 8'hED;
  localparam logic [7:0]  OP_QUAD_DTR4  = 8'hEE;
  localparam logic [7:0]  OP_UNIQUE_ID  = 8'h4B;
  localparam logic [7:0]  OP_INFO_ROW   = 8'h68;
  // Result word layout
  localparam int          RES_W         = 14;
  localparam int          RES_LEN_LO    = 0;
  localparam int          RES_LEN_HI    = 6;
  localparam int          RES_WRAP_POS  = 7;
  localparam int          RES_DUM_LO    = 8;
  localparam int          RES_DUM_HI    = 11;
  localparam int          RES_DTR_POS   = 12;
  localparam int          RES_OK_POS    = 13;
  localparam int          BUF_DEPTH     = 2;
  localparam logic [1:0]  STRAP_WAIT    = 2'h2;
endpackage : rdw_pkg

// file: common/rdw_buf_if.sv
`timescale 1ns/1ps
interface rdw_buf_if;
  import rdw_pkg::*;
  logic             push_valid;
  logic             push_ready;
  logic [RES_W-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [RES_W-1:0] pop_data;
  modport store (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data);
  modport user  (output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data);
endinterface : rdw_buf_if

// file: rtl/rdw_buf.sv
`timescale 1ns/1ps
module rdw_buf
  import rdw_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic nrst_i,
  rdw_buf_if.store  bus
);
  logic [RES_W-1:0] head_reg;
  logic [RES_W-1:0] tail_reg;
  logic [1:0]       cnt_reg;
  logic [1:0]       cnt_next;
  logic             valid_reg;
  wire              do_push = bus.push_valid && bus.push_ready;
  wire              do_pop  = valid_reg && bus.pop_ready;
  wire              head_ld = (cnt_reg == 2'h0) || (cnt_reg == 2'h1 && do_pop);

  assign bus.push_ready = (cnt_reg != 2'(BUF_DEPTH));
  assign bus.pop_valid  = valid_reg;
  assign bus.pop_data   = head_reg;
  assign cnt_next       = cnt_reg + 2'(do_push) - 2'(do_pop);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      head_reg  <= '0;
      tail_reg  <= '0;
      cnt_reg   <= 2'h0;
      valid_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      valid_reg <= (cnt_next != 2'h0);
      if (do_push && head_ld) begin
        head_reg <= bus.push_data;
      end else if (do_pop) begin
        head_reg <= tail_reg;
      end
      if (do_push && !head_ld) begin
        tail_reg <= bus.push_data;
      end
    end
  end
endmodule : rdw_buf

// file: rtl/rdw_top.sv
`timescale 1ns/1ps
module rdw_top
  import rdw_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               nrst_i,
  input  wire logic [PARAM_W-1:0] nv_param_i,
  input  wire logic               param_write_i,
  input  wire logic [PARAM_W-1:0] param_data_i,
  output logic      [PARAM_W-1:0] read_param_o,
  input  wire logic               link_clk_i,
  input  wire logic               cmd_strobe_i,
  input  wire logic [7:0]         cmd_i,
  input  wire logic               qpi_mode_i,
  output logic                    link_busy_o,
  output logic                    res_valid_o,
  input  wire logic               res_ready_i,
  output logic                    res_ok_o,
  output logic                    res_dtr_o,
  output logic      [3:0]         res_dummy_o,
  output logic                    res_wrap_en_o,
  output logic      [6:0]         res_wrap_len_o,
  output logic                    mode_bits_phase_oe_o
);
  // Link side: hold command, signal by toggle
  logic       req_tgl_reg;
  logic [7:0] cmd_hold_reg;
  logic       qpi_hold_reg;
  logic       ack_s1_reg;
  logic       ack_s2_reg;
  logic       link_busy_reg;
  logic       ack_tgl_reg;
  wire        link_take = cmd_strobe_i && !link_busy_reg;
  wire        req_tgl_next = req_tgl_reg ^ link_take;

  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_tgl_reg   <= 1'b0;
      cmd_hold_reg  <= 8'h00;
      qpi_hold_reg  <= 1'b0;
      ack_s1_reg    <= 1'b0;
      ack_s2_reg    <= 1'b0;
      link_busy_reg <= 1'b0;
    end else begin
      ack_s1_reg    <= ack_tgl_reg;
      ack_s2_reg    <= ack_s1_reg;
      req_tgl_reg   <= req_tgl_next;
      link_busy_reg <= (req_tgl_next != ack_s2_reg);
      if (link_take) begin
        cmd_hold_reg <= cmd_i;
        qpi_hold_reg <= qpi_mode_i;
      end
    end
  end

  assign link_busy_o = link_busy_reg;

  // Mode nibble is never driven by this block, keeping the lines free for the host
  logic mode_oe_reg;
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_oe_reg <= 1'b0;
    end else begin
      mode_oe_reg <= 1'b0;
    end
  end
  assign mode_bits_phase_oe_o = mode_oe_reg;

  // Core side: volatile read register loaded from nonvolatile strap
  logic [PARAM_W-1:0] nv_s1_reg;
  logic [PARAM_W-1:0] nv_s2_reg;
  logic [1:0]         strap_cnt_reg;
  logic               loaded_reg;
  logic [PARAM_W-1:0] vol_reg;
  logic               req_s1_reg;
  logic               req_s2_reg;
  logic               seen_reg;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nv_s1_reg     <= PARAM_RST;
      nv_s2_reg     <= PARAM_RST;
      strap_cnt_reg <= 2'h0;
      loaded_reg    <= 1'b0;
      vol_reg       <= PARAM_RST;
    end else begin
      nv_s1_reg <= nv_param_i;
      nv_s2_reg <= nv_s1_reg;
      if (!loaded_reg) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
        if (strap_cnt_reg == STRAP_WAIT) begin
          loaded_reg <= 1'b1;
          vol_reg    <= nv_s2_reg;
        end
      end else if (param_write_i) begin
        vol_reg <= param_data_i;
      end
    end
  end

  assign read_param_o = vol_reg;

  // Decode of the held command against the live volatile register
  wire        wrap_en   = vol_reg[WRAP_EN_POS];
  wire [1:0]  burst_sel = {vol_reg[BURST_HI_POS], vol_reg[BURST_LO_POS]};
  wire [3:0]  dummy_fld = vol_reg[DUMMY_HI_POS:DUMMY_LO_POS];
  wire        qpi       = qpi_hold_reg;
  wire [7:0]  op        = cmd_hold_reg;

  wire fam_single = (op == OP_FAST_RD) || (op == OP_FAST_RD4) || (op == OP_FAST_DTR)
                 || (op == OP_FAST_DTR4) || (op == OP_UNIQUE_ID) || (op == OP_INFO_ROW);
  wire fam_outx   = (op == OP_DUAL_OUT) || (op == OP_DUAL_OUT4)
                 || (op == OP_QUAD_OUT) || (op == OP_QUAD_OUT4);
  wire fam_dualio = (op == OP_DUAL_IO) || (op == OP_DUAL_IO4)
                 || (op == OP_DUAL_DTR) || (op == OP_DUAL_DTR4);
  wire fam_quadio = (op == OP_QUAD_IO) || (op == OP_QUAD_IO4)
                 || (op == OP_QUAD_DTR) || (op == OP_QUAD_DTR4);
  wire is_dtr     = (op == OP_FAST_DTR) || (op == OP_FAST_DTR4) || (op == OP_DUAL_DTR)
                 || (op == OP_DUAL_DTR4) || (op == OP_QUAD_DTR) || (op == OP_QUAD_DTR4);

  // Dual and output-only families are refused in QPI, covering the host's dual DTR ban
  wire cmd_ok = fam_single || fam_quadio || ((fam_outx || fam_dualio) && !qpi);

  wire [3:0] dummy_def = fam_single ? (qpi ? DUMMY_DEF_6 : DUMMY_DEF_8) :
                         fam_outx   ? DUMMY_DEF_8 :
                         fam_dualio ? DUMMY_DEF_4 :
                         fam_quadio ? DUMMY_DEF_6 : DUMMY_ZERO;
  wire [3:0] dummy_sel = (dummy_fld == DUMMY_ZERO) ? dummy_def : dummy_fld;

  wire [6:0] burst_len = (burst_sel == 2'h0) ? WRAP_LEN_8  :
                         (burst_sel == 2'h1) ? WRAP_LEN_16 :
                         (burst_sel == 2'h2) ? WRAP_LEN_32 : WRAP_LEN_64;
  // Zero length means wrap at the array end; burst bits then play no part
  wire [6:0] wrap_len  = wrap_en ? burst_len : WRAP_LEN_NONE;

  logic [RES_W-1:0] res_word;
  always_comb begin
    res_word                          = '0;
    res_word[RES_OK_POS]              = cmd_ok;
    res_word[RES_DTR_POS]             = is_dtr && cmd_ok;
    res_word[RES_DUM_HI:RES_DUM_LO]   = cmd_ok ? dummy_sel : DUMMY_ZERO;
    res_word[RES_WRAP_POS]            = wrap_en;
    res_word[RES_LEN_HI:RES_LEN_LO]   = wrap_len;
  end

  rdw_buf_if bq ();

  // Request is taken only when the buffer has room, so a stalled reader holds the link busy
  wire req_pend = (req_s2_reg != seen_reg) && loaded_reg;
  assign bq.push_valid = req_pend;
  assign bq.push_data  = res_word;
  assign bq.pop_ready  = res_ready_i;
  wire req_take = req_pend && bq.push_ready;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_s1_reg  <= 1'b0;
      req_s2_reg  <= 1'b0;
      seen_reg    <= 1'b0;
      ack_tgl_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      if (req_take) begin
        seen_reg    <= req_s2_reg;
        ack_tgl_reg <= req_s2_reg;
      end
    end
  end

  rdw_buf i_rdw_buf (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .bus     (bq)
  );

  assign res_valid_o    = bq.pop_valid;
  assign res_ok_o       = bq.pop_data[RES_OK_POS];
  assign res_dtr_o      = bq.pop_data[RES_DTR_POS];
  assign res_dummy_o    = bq.pop_data[RES_DUM_HI:RES_DUM_LO];
  assign res_wrap_en_o  = bq.pop_data[RES_WRAP_POS];
  assign res_wrap_len_o = bq.pop_data[RES_LEN_HI:RES_LEN_LO];
endmodule : rdw_top

// file: sim/rdw_top_sva.sv
`timescale 1ns/1ps
module rdw_top_sva
  import rdw_pkg::*;
(
  input wire logic               clock_i,
  input wire logic               nrst_i,
  input wire logic               link_clk_i,
  input wire logic               cmd_strobe_i,
  input wire logic               link_busy_o,
  input wire logic               param_write_i,
  input wire logic [PARAM_W-1:0] param_data_i,
  input wire logic [PARAM_W-1:0] read_param_o,
  input wire logic               res_valid_o,
  input wire logic               res_ready_i,
  input wire logic               res_ok_o,
  input wire logic               res_dtr_o,
  input wire logic [3:0]         res_dummy_o,
  input wire logic               res_wrap_en_o,
  input wire logic [6:0]         res_wrap_len_o,
  input wire logic               mode_bits_phase_oe_o
);
  AST_WRAP_OFF: assert property (@(posedge clock_i) disable iff (!nrst_i)
    res_valid_o && !res_wrap_en_o |-> res_wrap_len_o == WRAP_LEN_NONE)
    else $error("wrap length set while wrap disabled");
  // Settings held for 4 cycles so the take-time value is known
  AST_TAKE_CFG: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(res_valid_o) && read_param_o == $past(read_param_o, 4) |->
    res_wrap_en_o == read_param_o[WRAP_EN_POS]
    && res_wrap_len_o == (read_param_o[2] ? 7'(8 << read_param_o[1:0]) : WRAP_LEN_NONE)
    && (!res_ok_o || read_param_o[6:3] == 4'h0 || res_dummy_o == read_param_o[6:3]))
    else $error("result does not follow read settings");
  AST_NOTOK: assert property (@(posedge clock_i) disable iff (!nrst_i)
    res_valid_o && !res_ok_o |-> res_dummy_o == DUMMY_ZERO && !res_dtr_o)
    else $error("refused read reports dummy or dtr");
  AST_OK_DUMMY: assert property (@(posedge clock_i) disable iff (!nrst_i)
    res_valid_o && res_ok_o |-> res_dummy_o != DUMMY_ZERO)
    else $error("accepted read has zero dummy clocks");
  AST_HOLD: assert property (@(posedge clock_i) disable iff (!nrst_i)
    res_valid_o && !res_ready_i |=> res_valid_o
    && $stable({res_ok_o, res_dtr_o, res_dummy_o, res_wrap_en_o, res_wrap_len_o}))
    else $error("stalled result changed");
  AST_VOL_WRITE: assert property (@(posedge clock_i) disable iff (!nrst_i)
    param_write_i |=> read_param_o == $past(param_data_i))
    else $error("volatile write not applied");
  AST_BUSY_TAKE: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
    cmd_strobe_i && !link_busy_o |=> link_busy_o)
    else $error("taken command did not raise busy");
  AST_NO_DRIVE: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
    mode_bits_phase_oe_o == 1'b0)
    else $error("mode nibble driven");
endmodule : rdw_top_sva

bind rdw_top rdw_top_sva i_rdw_top_sva (.clock_i, .nrst_i, .link_clk_i, .cmd_strobe_i,
  .link_busy_o, .param_write_i, .param_data_i, .read_param_o, .res_valid_o, .res_ready_i,
  .res_ok_o, .res_dtr_o, .res_dummy_o, .res_wrap_en_o, .res_wrap_len_o, .mode_bits_phase_oe_o);

// file: sim/rdw_host_model.sv
`timescale 1ns/1ps
module rdw_host_model (
  input  wire logic  link_clk_i,
  input  wire logic  nrst_i,
  input  wire logic  link_busy_i,
  output logic       cmd_strobe_o,
  output logic [7:0] cmd_o,
  output logic       qpi_mode_o
);
  initial begin
    cmd_strobe_o = 1'b0;
    cmd_o = 8'h00;
    qpi_mode_o = 1'b0;
  end
  task automatic send(input logic [7:0] op, input logic qpi);
    // Falling-edge drive: the rising edge takes a settled request, one in flight only
    do begin
      @(negedge link_clk_i);
    end while (link_busy_i !== 1'b0 || nrst_i !== 1'b1);
    cmd_strobe_o = 1'b1;
    cmd_o = op;
    qpi_mode_o = qpi;
    @(negedge link_clk_i);
    cmd_strobe_o = 1'b0;
    // Released lines show the inverse, never a stale opcode
    cmd_o = ~op;
    qpi_mode_o = ~qpi;
  endtask : send
endmodule : rdw_host_model

// file: sim/read_dummy_wrap_config_tb.sv
`timescale 1ns/1ps
module read_dummy_wrap_config_tb;
  import rdw_pkg::*;
  logic       clock_i, nrst_i, link_clk_i, param_write_i, res_ready_i, cmd_strobe_i;
  logic       qpi_mode_i, link_busy_o, res_valid_o, res_ok_o, res_dtr_o;
  logic       res_wrap_en_o, mode_bits_phase_oe_o;
  logic [7:0] nv_param_i, param_data_i, read_param_o, cmd_i;
  logic [3:0] res_dummy_o, dum;
  logic [6:0] res_wrap_len_o;
  int         error_cnt, samples_checked, cyc, i;
  // Expect: qpi, ok, dtr, unused, dummy[3:0]
  logic [7:0] ops [19] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h4B, 8'h68, 8'h3B, 8'h3C, 8'h6B,
    8'h6C, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hEB, 8'hEC, 8'hED, 8'hEE, 8'h03};
  logic [7:0] exps [19] = '{8'h48, 8'hC6, 8'h68, 8'hE6, 8'hC6, 8'h48, 8'h48, 8'h80, 8'h48,
    8'h80, 8'h44, 8'h80, 8'h64, 8'h64, 8'hC6, 8'h46, 8'hE6, 8'h66, 8'h00};

  rdw_top i_rdw_top (.clock_i, .nrst_i, .nv_param_i, .param_write_i, .param_data_i,
    .read_param_o, .link_clk_i, .cmd_strobe_i, .cmd_i, .qpi_mode_i, .link_busy_o, .res_valid_o,
    .res_ready_i, .res_ok_o, .res_dtr_o, .res_dummy_o, .res_wrap_en_o, .res_wrap_len_o,
    .mode_bits_phase_oe_o);
  rdw_host_model i_rdw_host_model (.link_clk_i, .nrst_i, .link_busy_i(link_busy_o),
    .cmd_strobe_o(cmd_strobe_i), .cmd_o(cmd_i), .qpi_mode_o(qpi_mode_i));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #4.1;
    forever #7.5 link_clk_i = ~link_clk_i;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic set_param(input logic [7:0] v);
    @(negedge clock_i);
    param_data_i = v;
    param_write_i = 1'b1;
    @(negedge clock_i);
    param_write_i = 1'b0;
    param_data_i = ~v;
  endtask : set_param
  task automatic get(input logic [5:0] okdum, input logic wen, input logic [6:0] len);
    @(negedge clock_i);
    while (res_valid_o !== 1'b1) @(negedge clock_i);
    chk("result", {okdum, wen, len},
      {res_ok_o, res_dtr_o, res_dummy_o, res_wrap_en_o, res_wrap_len_o});
    res_ready_i = 1'b1;
    @(negedge clock_i);
    res_ready_i = 1'b0;
  endtask : get
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    nrst_i = 1'b0;
    nv_param_i = 8'h07;
    param_write_i = 1'b0;
    param_data_i = 8'h00;
    res_ready_i = 1'b0;
    repeat (3) @(negedge clock_i);
    nrst_i = 1'b1;
    repeat (6) @(negedge clock_i);
    chk("read_param", 14'h0007, {6'h00, read_param_o});
    i_rdw_host_model.send(OP_FAST_RD, 1'b0);
    get(6'h28, 1'b1, WRAP_LEN_64);
    set_param(8'h03);
    for (i = 0; i < 19; i++) begin
      i_rdw_host_model.send(ops[i], exps[i][7]);
      get({exps[i][6:5], exps[i][3:0]}, 1'b0, WRAP_LEN_NONE);
    end
    for (i = 0; i < 4; i++) begin
      // Counts cover the mode-bit clocks and keep the ceiling above the link rate
      dum = (i == 3) ? 4'hF : 4'(i + 5);
      set_param({1'b0, dum, 1'b1, i[1:0]});
      i_rdw_host_model.send(OP_QUAD_IO, 1'b1);
      get({2'b10, dum}, 1'b1, 7'(8 << i));
    end
    // Third command parks behind a full buffer and picks up the later write
    set_param(8'h00);
    i_rdw_host_model.send(OP_FAST_RD, 1'b0);
    i_rdw_host_model.send(OP_DUAL_IO, 1'b0);
    i_rdw_host_model.send(OP_QUAD_IO, 1'b0);
    set_param(8'h7C);
    repeat (10) @(negedge clock_i);
    chk("busy_valid", 14'h0003, {11'h000, mode_bits_phase_oe_o, link_busy_o, res_valid_o});
    get(6'h28, 1'b0, WRAP_LEN_NONE);
    get(6'h24, 1'b0, WRAP_LEN_NONE);
    get(6'h2F, 1'b1, WRAP_LEN_8);
    @(negedge clock_i);
    chk("drained", 14'h0000, {13'h0000, res_valid_o});
    complete_run();
  end
endmodule : read_dummy_wrap_config_tb
